/* fsad_asserts.sv */
// Checker of the link between the slave end and the master end
`timescale 1ns/10ps
`default_nettype none
module fsad_asserts (
	// Clock and reset
	input wire logic                        hclk,
	input wire logic                        hresetn,
	// Link signals
	input wire logic [fsad_pkg::ADDR_W-1:0] mst_addr,
	input wire logic                        diag_req,
	input wire logic                        alm_ack,
	input wire logic                        online,
	input wire logic                        var_v1,
	input wire logic                        alarm,
	input wire logic                        diag_vld,
	input wire logic [7:0]                  diag_byte,
	input wire logic                        diag_last
);
	import fsad_pkg::*;
	// Byte position within the frame
	logic      [3:0] cnt_r;
	wire logic [3:0] cnt_nxt = (diag_vld && !diag_last) ? cnt_r + 4'h1 : 4'h0;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cnt_r <= 4'h0;
		else
			cnt_r <= cnt_nxt;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_frame_len: assert property (
		diag_vld && diag_last |-> cnt_r == 4'hb) else $error("bad length");
	chk_byte_gap: assert property (
		diag_vld && !diag_last |=> diag_vld) else $error("gap in frame");
	chk_no_exist: assert property (
		diag_vld && cnt_r == 4'h0 |-> !diag_byte[ST1_NEXIST])
		else $error("nonexistent flag set");
	chk_from_slave: assert property (
		diag_vld && cnt_r == 4'h1 |-> diag_byte[ST2_SFS])
		else $error("slave flag clear");
	chk_master_addr: assert property (
		diag_vld && cnt_r == 4'h3 |-> diag_byte == {1'b0, $past(mst_addr)})
		else $error("master address byte wrong");
	chk_ident_code: assert property (
		diag_vld && cnt_r == 4'h4 |=> diag_byte == IDENT[7:0]
		&& $past(diag_byte) == IDENT[15:8]) else $error("ident wrong");
	chk_dev_type: assert property (
		diag_vld && cnt_r == 4'h7 && $past(var_v1) |-> diag_byte == INT_TYPE)
		else $error("interrupt type wrong");
	chk_req_answer: assert property (
		diag_req && online && !diag_vld |-> ##2 diag_vld)
		else $error("frame late");
	chk_ack_clear: assert property (
		alm_ack && var_v1 |=> !alarm) else $error("alarm kept after ack");
	chk_v0_alarm: assert property (
		diag_vld && diag_last && !var_v1 |-> !alarm)
		else $error("alarm kept in v0");
	chk_v0_no_ack: assert property (
		!var_v1 |-> !alm_ack) else $error("ack in v0");
	cov_ack: cover property (alm_ack);
	cov_v0_frame: cover property (diag_last && !var_v1);
	cov_online: cover property ($rose(online));
endmodule : fsad_asserts
`default_nettype wire

/* fsad_if.sv */
// Link between the fieldbus slave end and the bus master end
`timescale 1ns/10ps
`default_nettype none
interface fsad_if;
	import fsad_pkg::*;
	logic              mst_set;
	logic              mst_v1;
	logic [ADDR_W-1:0] mst_addr;
	logic              diag_req;
	logic              alm_ack;
	logic              online;
	logic [ADDR_W-1:0] slv_addr;
	logic              var_v1;
	logic              alarm;
	logic              diag_vld;
	logic [7:0]        diag_byte;
	logic              diag_last;
	modport slave (
		input  mst_set, mst_v1, mst_addr, diag_req, alm_ack,
		output online, slv_addr, var_v1, alarm,
		output diag_vld, diag_byte, diag_last
	);
	modport master (
		output mst_set, mst_v1, mst_addr, diag_req, alm_ack,
		input  online, slv_addr, var_v1, alarm,
		input  diag_vld, diag_byte, diag_last
	);
endinterface : fsad_if
`default_nettype wire

/* fsad_master.sv */
// Bus master end: fetches diagnostics, acknowledges them in DP-V1 only, AHB-Lite regs
`timescale 1ns/10ps
`default_nettype none
module fsad_master (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave port
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Interrupt
	output logic             irq,
	// Link to the slave
	fsad_if.master           link
);
	import fsad_pkg::*;

	logic [7:0]           dbuf_r [DIAG_LEN];
	logic [95:0]          dflat;
	logic [DIX_W-1:0]     ridx_r;
	fsad_mst_t            mst_r;
	logic                 ap;
	logic                 wr_r;
	logic [OFF_W-1:0]     wa_r;
	logic [31:0]          rd_nxt;
	logic [31:0]          rd_r;
	logic [15:0]          ctrl_r;
	logic                 poll_r;
	logic                 issue;
	logic                 req_r;
	logic                 ack_r;
	logic                 rx_end;
	logic                 onl_q;
	logic                 alm_q;
	logic [IRQ_W-1:0]     ev;
	logic [IRQ_W-1:0]     ist_r;
	logic [IRQ_W-1:0]     ien_r;
	logic                 irq_r;
	logic                 w_ctrl;
	logic                 w_cmd;
	logic                 w_iclr;
	logic                 w_ien;

	genvar g;
	generate
		for (g = 0; g < DIAG_LEN; g++)
		begin : g_flat
			assign dflat[g*8 +: 8] = dbuf_r[g];
		end
	endgenerate

	assign ap     = hsel && htrans[1] && hready;
	assign w_ctrl = wr_r && (wa_r == R_CTRL);
	assign w_cmd  = wr_r && (wa_r == R_CMD);
	assign w_iclr = wr_r && (wa_r == R_ICLR);
	assign w_ien  = wr_r && (wa_r == R_IEN);

	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		if (haddr[31:OFF_W] == '0)
			case (haddr[OFF_W-1:0])
				R_CTRL:  rd_nxt = {16'h0000, ctrl_r};
				R_STAT:  rd_nxt = {21'h0, mst_r == M_RX, link.alarm,
					link.online, 1'b0, link.slv_addr};
				R_DIAG0: rd_nxt = dflat[31:0];
				R_DIAG1: rd_nxt = dflat[63:32];
				R_DIAG2: rd_nxt = dflat[95:64];
				R_ISTAT: rd_nxt = {29'h0, ist_r};
				R_IEN:   rd_nxt = {29'h0, ien_r};
				default: rd_nxt = 32'h0000_0000;
			endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_r   <= 1'b0;
			wa_r   <= '0;
			rd_r   <= 32'h0000_0000;
			ctrl_r <= CTRL_RST;
			ien_r  <= '0;
		end
		else
		begin
			wr_r   <= ap && hwrite && (haddr[31:OFF_W] == '0);
			wa_r   <= haddr[OFF_W-1:0];
			rd_r   <= (ap && !hwrite) ? rd_nxt : rd_r;
			ctrl_r <= w_ctrl ? hwdata[15:0] : ctrl_r;
			ien_r  <= w_ien ? hwdata[IRQ_W-1:0] : ien_r;
		end
	end

	// Fetch on alarm or on software poll
	assign issue  = (mst_r == M_IDLE) && link.online && !ack_r
		&& (poll_r || link.alarm);
	assign rx_end = (mst_r == M_RX) && link.diag_vld && link.diag_last;
	assign ev     = {link.alarm && !alm_q, link.online && !onl_q, rx_end};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mst_r  <= M_IDLE;
			ridx_r <= '0;
			req_r  <= 1'b0;
			ack_r  <= 1'b0;
			poll_r <= 1'b0;
			onl_q  <= 1'b0;
			alm_q  <= 1'b0;
			ist_r  <= '0;
			irq_r  <= 1'b0;
			for (int i = 0; i < DIAG_LEN; i++)
				dbuf_r[i] <= 8'h00;
		end
		else
		begin
			req_r  <= issue;
			// RULE9: acknowledge each interrupt
			// RULE10: no acknowledge in DP-V0
			ack_r  <= rx_end && link.var_v1;
			poll_r <= (w_cmd && hwdata[0]) || (poll_r && !issue);
			onl_q  <= link.online;
			alm_q  <= link.alarm;
			ist_r  <= ev | (ist_r & ~(w_iclr ? hwdata[IRQ_W-1:0] : '0));
			irq_r  <= |(ist_r & ien_r);
			if (mst_r == M_RX && link.diag_vld && ridx_r < DIAG_LEN)
			begin
				dbuf_r[ridx_r] <= link.diag_byte;
				ridx_r         <= ridx_r + 1'b1;
			end
			case (mst_r)
				M_IDLE:
				begin
					ridx_r <= '0;
					mst_r  <= issue ? M_RX : M_IDLE;
				end
				M_RX: mst_r <= (rx_end || !link.online) ? M_IDLE : M_RX;
				default: mst_r <= M_IDLE;
			endcase
		end
	end

	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign hrdata        = rd_r;
	assign irq           = irq_r;
	assign link.mst_v1   = ctrl_r[CTL_V1];
	assign link.mst_set  = ctrl_r[CTL_SET];
	assign link.mst_addr = ctrl_r[CTL_MA +: ADDR_W];
	assign link.diag_req = req_r;
	assign link.alm_ack  = ack_r;
endmodule : fsad_master
`default_nettype wire

/* fsad_pkg.sv */
// Constants and types of the address-change and diagnostics block
// How it works
// RULE1: Valid address record restarts slave at new address
// RULE2: Record: version high, low, opcode, address
// RULE3: Bad record gives error, address kept
// RULE4: Latest of several records wins
// RULE5: Slave first joins under configured address
// RULE6: Host writes records only in run state
// RULE7: Master setting picks the protocol variant
// RULE8: Variant defaults to DP-V1
// RULE9: DP-V1 diagnostics interrupt, master acknowledges
// RULE10: DP-V0 diagnostics alarm, never acknowledged
// RULE11: Six standard plus six device bytes
// RULE12: Status 1-3, master address, ident code
// RULE13: Device block differs per variant
// RULE14: Extended-diagnostics flag when data present
// RULE15: Station-nonexistent flag always zero
// RULE16: Status-from-slave flag always one
// RULE17: Only record version 1.0 accepted
`default_nettype none
package fsad_pkg;
	// Link and record widths
	localparam int ADDR_W = 7;
	localparam int IDX_W = 16;
	localparam int LEN_W = 3;
	localparam int REC_W = 32;
	localparam int DIX_W = 4;
	// Address-change record
	localparam logic [IDX_W-1:0] REC_IDX = 16'h2001;
	localparam logic [15:0] REC_VER = 16'h0100;
	localparam logic [7:0] OP_KEEP = 8'h00;
	localparam logic [7:0] OP_CHANGE = 8'h01;
	localparam logic [LEN_W-1:0] REC_MIN_LEN = 3'h4;
	localparam logic [7:0] ADDR_MAX = 8'h7d;
	localparam int VER_POS = 16;
	localparam int OP_POS = 8;
	localparam int NA_POS = 0;
	// Restart time
	localparam int CLK_MHZ = 200;
	localparam int RESTART_US = 10;
	localparam int RESTART_CYC = RESTART_US * CLK_MHZ;
	localparam int RCNT_W = 12;
	// Diagnostics frame
	localparam logic [DIX_W-1:0] DIAG_LEN = 4'hc;
	localparam logic [DIX_W-1:0] DIAG_LAST = 4'hb;
	localparam int ST1_NEXIST = 0;
	localparam int ST1_EXT = 3;
	localparam int ST2_SFS = 2;
	localparam logic [15:0] IDENT = 16'h5a5a; // Arbitrary value
	localparam logic [7:0] DEV_HDR = 8'h06;
	localparam logic [7:0] INT_TYPE = 8'h01;
	localparam logic [7:0] SLOT_NR = 8'h00;
	localparam logic [7:0] SPEC_COME = 8'h01;
	localparam logic [7:0] SPEC_GO = 8'h02;
	// Controller registers
	localparam int OFF_W = 8;
	localparam logic [OFF_W-1:0] R_CTRL = 8'h00;
	localparam logic [OFF_W-1:0] R_CMD = 8'h04;
	localparam logic [OFF_W-1:0] R_STAT = 8'h08;
	localparam logic [OFF_W-1:0] R_DIAG0 = 8'h0c;
	localparam logic [OFF_W-1:0] R_DIAG1 = 8'h10;
	localparam logic [OFF_W-1:0] R_DIAG2 = 8'h14;
	localparam logic [OFF_W-1:0] R_ISTAT = 8'h18;
	localparam logic [OFF_W-1:0] R_ICLR = 8'h1c;
	localparam logic [OFF_W-1:0] R_IEN = 8'h20;
	localparam int CTL_V1 = 0;
	localparam int CTL_SET = 1;
	localparam int CTL_MA = 8;
	localparam logic [15:0] CTRL_RST = 16'h0101;
	localparam int IRQ_W = 3;
	// State types
	typedef enum logic [1:0] {L_INIT, L_ON, L_RST} fsad_link_t;
	typedef enum logic {D_IDLE, D_SEND} fsad_diag_t;
	typedef enum logic {M_IDLE, M_RX} fsad_mst_t;
endpackage : fsad_pkg
`default_nettype wire

/* fsad_slave.sv */
// Slave end: address-change records and diagnostics source
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module fsad_slave (
	// Clock and reset
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	// Link to the bus master
	fsad_if.slave                            link,
	// Configured address and variant
	input  wire logic [fsad_pkg::ADDR_W-1:0] cfg_addr,
	input  wire logic                        cfg_var_set,
	input  wire logic                        cfg_var_v1,
	// Data record writes from the host
	input  wire logic                        rec_valid,
	input  wire logic [fsad_pkg::IDX_W-1:0]  rec_index,
	input  wire logic [fsad_pkg::LEN_W-1:0]  rec_len,
	input  wire logic [fsad_pkg::REC_W-1:0]  rec_data,
	output logic                             rec_done,
	output logic                             rec_err,
	// Device diagnostic events
	input  wire logic                        ev_valid,
	input  wire logic [7:0]                  ev_code,
	input  wire logic                        ev_clear,
	// Address in use
	output logic [fsad_pkg::ADDR_W-1:0]      cur_addr
);
	import fsad_pkg::*;

	function automatic logic [7:0] diag_at(
		input logic [DIX_W-1:0] i,
		input logic             v1,
		input logic             ext,
		input logic [ADDR_W-1:0] ma,
		input logic [7:0]       code
	);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			// RULE14: extended flag
			// RULE15: nonexistent flag zero
			4'h0: b[ST1_EXT] = ext;
			// RULE16: status from slave
			4'h1: b[ST2_SFS] = 1'b1;
			4'h3: b = {1'b0, ma};
			4'h4: b = IDENT[15:8];
			4'h5: b = IDENT[7:0];
			4'h6: b = DEV_HDR;
			// RULE13: variant-specific content
			4'h7: b = v1 ? INT_TYPE : code;
			4'h8: b = v1 ? SLOT_NR : 8'h00;
			4'h9: b = v1 ? (ext ? SPEC_COME : SPEC_GO) : 8'h00;
			4'ha: b = v1 ? code : 8'h00;
			default: b = 8'h00;
		endcase
		return b;
	endfunction : diag_at

	logic [15:0]       rec_ver;
	logic [7:0]        rec_op;
	logic [7:0]        rec_na;
	logic              rec_hit;
	logic              rec_ok;
	logic              chg_ok;
	logic              done_r;
	logic              err_r;
	fsad_link_t        lst_r;
	fsad_link_t        lst_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [ADDR_W-1:0] new_r;
	logic [ADDR_W-1:0] new_nxt;
	logic [RCNT_W-1:0] cnt_r;
	logic [RCNT_W-1:0] cnt_nxt;
	logic              online_r;
	logic              online_nxt;
	logic              var_r;
	logic              v1_nxt;
	logic              ext_r;
	logic [7:0]        code_r;
	logic              alm_r;
	logic              alm_done;
	fsad_diag_t        dst_r;
	logic [DIX_W-1:0]  didx_r;
	logic              d_start;
	logic              d_end;
	logic              dvld_r;
	logic [7:0]        dbyte_r;
	logic              dlast_r;

	// RULE2: record field layout
	assign rec_ver = rec_data[VER_POS +: 16];
	assign rec_op  = rec_data[OP_POS +: 8];
	assign rec_na  = rec_data[NA_POS +: 8];
	assign rec_hit = rec_index == REC_IDX;
	// RULE3: reject malformed record
	// RULE17: version 1.0 only
	assign rec_ok  = rec_hit && (rec_ver == REC_VER)
		&& (rec_len >= REC_MIN_LEN)
		&& ((rec_op == OP_KEEP)
		|| ((rec_op == OP_CHANGE) && (rec_na <= ADDR_MAX)));
	assign chg_ok  = rec_valid && rec_ok && (rec_op == OP_CHANGE);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_r <= 1'b0;
			err_r  <= 1'b0;
		end
		else
		begin
			done_r <= rec_valid && rec_ok;
			// RULE3: general error answer
			err_r  <= rec_valid && !rec_ok;
		end
	end

	always_comb
	begin
		lst_nxt    = lst_r;
		addr_nxt   = addr_r;
		new_nxt    = new_r;
		cnt_nxt    = cnt_r;
		online_nxt = online_r;
		case (lst_r)
			L_INIT:
			begin
				// RULE5: join with configured address
				addr_nxt   = cfg_addr;
				online_nxt = 1'b1;
				lst_nxt    = L_ON;
			end
			L_ON:
			begin
				// RULE1: leave bus and restart
				if (chg_ok)
				begin
					new_nxt    = rec_na[ADDR_W-1:0];
					cnt_nxt    = RCNT_W'(RESTART_CYC - 1);
					online_nxt = 1'b0;
					lst_nxt    = L_RST;
				end
			end
			L_RST:
			begin
				// RULE4: newest record wins
				if (chg_ok)
				begin
					new_nxt = rec_na[ADDR_W-1:0];
					cnt_nxt = RCNT_W'(RESTART_CYC - 1);
				end
				else if (cnt_r == '0)
				begin
					// RULE1: rejoin at new address
					addr_nxt   = new_r;
					online_nxt = 1'b1;
					lst_nxt    = L_ON;
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			default: lst_nxt = L_INIT;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lst_r    <= L_INIT;
			addr_r   <= '0;
			new_r    <= '0;
			cnt_r    <= '0;
			online_r <= 1'b0;
		end
		else
		begin
			lst_r    <= lst_nxt;
			addr_r   <= addr_nxt;
			new_r    <= new_nxt;
			cnt_r    <= cnt_nxt;
			online_r <= online_nxt;
		end
	end

	// RULE7: master setting decides
	// RULE8: default to DP-V1
	assign v1_nxt = link.mst_set ? link.mst_v1
		: (cfg_var_set ? cfg_var_v1 : 1'b1);
	// RULE9: acknowledge ends interrupt
	// RULE10: alarm ends with its frame
	assign alm_done = var_r ? link.alm_ack : d_end;
	assign d_start = (dst_r == D_IDLE) && link.diag_req && online_r;
	assign d_end = (dst_r == D_SEND) && (didx_r == DIAG_LAST);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			var_r  <= 1'b1;
			ext_r  <= 1'b0;
			code_r <= 8'h00;
			alm_r  <= 1'b0;
		end
		else
		begin
			var_r  <= v1_nxt;
			// RULE14: sticky diagnostics present
			ext_r  <= ev_valid || (ext_r && !ev_clear);
			code_r <= ev_valid ? ev_code : code_r;
			alm_r  <= ev_valid || (alm_r && !alm_done);
		end
	end

	// RULE11: twelve-byte diagnostics frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dst_r   <= D_IDLE;
			didx_r  <= '0;
			dvld_r  <= 1'b0;
			dbyte_r <= 8'h00;
			dlast_r <= 1'b0;
		end
		else
		begin
			dvld_r  <= dst_r == D_SEND;
			dlast_r <= d_end;
			// RULE12: standard block layout
			dbyte_r <= diag_at(didx_r, var_r, ext_r, link.mst_addr,
				code_r);
			didx_r  <= (dst_r == D_SEND) ? didx_r + 1'b1 : '0;
			case (dst_r)
				D_IDLE: dst_r <= d_start ? D_SEND : D_IDLE;
				D_SEND: dst_r <= d_end ? D_IDLE : D_SEND;
				default: dst_r <= D_IDLE;
			endcase
		end
	end

	assign rec_done       = done_r;
	assign rec_err        = err_r;
	assign cur_addr       = addr_r;
	assign link.online    = online_r;
	assign link.slv_addr  = addr_r;
	assign link.var_v1    = var_r;
	assign link.alarm     = alm_r;
	assign link.diag_vld  = dvld_r;
	assign link.diag_byte = dbyte_r;
	assign link.diag_last = dlast_r;
endmodule : fsad_slave
`default_nettype wire

/* tb_top.sv */
// Testbench of the address-change and diagnostics block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module tb_top;
	import fsad_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rec_data = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2, rec_len = 3'h0;
	logic        hready, hreadyout, hresp, irq, rec_done, rec_err;
	logic        cfg_var_set = 1'b0, cfg_var_v1 = 1'b0, rec_valid = 1'b0;
	logic        ev_valid = 1'b0, ev_clear = 1'b0;
	logic [7:0]  ev_code = 8'h0;
	logic [15:0] rec_index = 16'h0;
	logic [6:0]  cfg_addr = 7'h0, cur_addr;
	int          n_fail = 0, total_checks = 0, cyc = 0;
	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;
	fsad_if lk();
	fsad_slave u_fsad_slave (.hclk(hclk), .hresetn(hresetn), .link(lk),
		.cfg_addr(cfg_addr), .cfg_var_set(cfg_var_set), .cfg_var_v1(cfg_var_v1),
		.rec_valid(rec_valid), .rec_index(rec_index), .rec_len(rec_len),
		.rec_data(rec_data), .rec_done(rec_done), .rec_err(rec_err),
		.ev_valid(ev_valid), .ev_code(ev_code), .ev_clear(ev_clear),
		.cur_addr(cur_addr));
	fsad_master u_fsad_master (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .irq(irq), .link(lk));
	fsad_asserts u_fsad_asserts (.hclk(hclk), .hresetn(hresetn),
		.mst_addr(lk.mst_addr), .diag_req(lk.diag_req), .alm_ack(lk.alm_ack),
		.online(lk.online), .var_v1(lk.var_v1), .alarm(lk.alarm),
		.diag_vld(lk.diag_vld), .diag_byte(lk.diag_byte),
		.diag_last(lk.diag_last));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic rec(input logic [15:0] ix, input logic [2:0] ln,
		input logic [31:0] dt, input logic ok);
		@(posedge hclk);
		rec_valid <= 1'b1;
		rec_index <= ix;
		rec_len <= ln;
		rec_data <= dt;
		@(posedge hclk);
		rec_valid <= 1'b0;
		#1;
		`CHK({rec_done, rec_err}, {ok, !ok})
	endtask : rec
	task automatic pulse_ev(input logic clr, input logic [7:0] c);
		@(posedge hclk);
		ev_valid <= !clr;
		ev_clear <= clr;
		ev_code <= c;
		@(posedge hclk);
		ev_valid <= 1'b0;
		ev_clear <= 1'b0;
	endtask : pulse_ev
	function automatic logic [95:0] exp_diag(logic v1, ext, logic [6:0] ma,
		logic [7:0] c);
		return {8'h0, v1 ? c : 8'h0, v1 ? (ext ? SPEC_COME : SPEC_GO) : 8'h0,
			SLOT_NR, v1 ? INT_TYPE : c, DEV_HDR, IDENT[7:0], IDENT[15:8],
			1'b0, ma, 8'h0, 8'h04, 4'h0, ext, 3'h0};
	endfunction : exp_diag
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end
	initial
	begin
		logic [31:0] q;
		logic [95:0] d, mk;
		logic [6:0]  ca, a2, ma;
		logic [7:0]  c;
		logic        v1, ev;
		int          n;
		void'($urandom(83));
		ca = 7'($urandom_range(125));
		cfg_addr <= ca;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		#1;
		`CHK({lk.online, lk.slv_addr}, {1'b1, ca})
		`CHK(lk.var_v1, 1'b1)
		bus(0, R_CTRL, 0, q);
		`CHK(q[15:0], CTRL_RST)
		bus(0, 32'h100, 0, q);
		`CHK(q, 32'h0)
		`CHK({hresp, hreadyout}, 2'b01)
		cfg_var_set <= 1'b1;
		repeat (3) @(posedge hclk);
		`CHK(lk.var_v1, 1'b0)
		cfg_var_set <= 1'b0;
		$display("test startup done");
		rec(16'h2002, 3'h4, {REC_VER, OP_CHANGE, 8'h10}, 0);
		rec(REC_IDX, 3'h4, 32'h0200_0110, 0);
		rec(REC_IDX, 3'h4, 32'h0101_0110, 0);
		rec(REC_IDX, 3'h3, {REC_VER, OP_CHANGE, 8'h10}, 0);
		rec(REC_IDX, 3'h4, {REC_VER, 8'h02, 8'h10}, 0);
		rec(REC_IDX, 3'h4, {REC_VER, OP_CHANGE, 8'h7e}, 0);
		rec(REC_IDX, 3'h4, {REC_VER, OP_KEEP, 8'h33}, 1);
		`CHK({lk.online, cur_addr}, {1'b1, ca})
		a2 = 7'($urandom_range(125));
		rec(REC_IDX, 3'h4, {REC_VER, OP_CHANGE, 8'h7d}, 1);
		rec(REC_IDX, 3'h4, {REC_VER, OP_CHANGE, 1'b0, a2}, 1);
		`CHK(lk.online, 1'b0)
		n = 0;
		while (lk.online !== 1'b1 && n < 2100)
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		`CHK(n >= 1995 && n <= 2005, 1'b1)
		`CHK({lk.slv_addr, cur_addr}, {a2, a2})
		bus(0, R_STAT, 0, q);
		`CHK({q[8], q[6:0]}, {1'b1, a2})
		$display("test records done");
		bus(1, R_IEN, 32'h7, q);
		bus(1, R_ICLR, 32'h7, q);
		cfg_var_set <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			v1 = (i % 2) == 0;
			ev = i < 2;
			ma = 7'($urandom_range(125, 1));
			c = 8'($urandom);
			bus(1, R_CTRL, {17'h0, ma, 6'h0, 1'b1, v1}, q);
			if (ev)
				pulse_ev(1'b0, c);
			else
			begin
				pulse_ev(1'b1, 8'h0);
				bus(1, R_CMD, 32'h1, q);
			end
			n = 0;
			do
			begin
				bus(0, R_ISTAT, 0, q);
				n++;
			end
			while (q[0] !== 1'b1 && n < 20);
			`CHK({q[2], q[0]}, {ev, 1'b1})
			repeat (4) @(posedge hclk);
			#1;
			`CHK({lk.alarm, lk.var_v1}, {1'b0, v1})
			bus(0, R_DIAG0, 0, q);
			d[31:0] = q;
			bus(0, R_DIAG1, 0, q);
			d[63:32] = q;
			bus(0, R_DIAG2, 0, q);
			d[95:64] = q;
			mk = ev ? 96'h0 : exp_diag(v1, 0, 0, 8'hff) ^ exp_diag(v1, 0, 0, 0);
			mk = ~mk & {80'hffff_ffff_ffff_ffff_ffff, 8'h04, 8'h09};
			`CHK(d & mk, exp_diag(v1, ev, ma, c) & mk)
			`CHK(irq, 1'b1)
			bus(1, R_IEN, 32'h0, q);
			bus(0, R_STAT, 0, q);
			`CHK(irq, 1'b0)
			bus(1, R_IEN, 32'h7, q);
			bus(0, R_STAT, 0, q);
			`CHK(irq, 1'b1)
			bus(1, R_ICLR, 32'h7, q);
			bus(0, R_STAT, 0, q);
			`CHK(irq, 1'b0)
			$display("test diagnostics %0d done", i);
		end
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
